// [rtl/gpio_pullup_latch_logic.sv]
// Port latches, direction and pull-up selection registers for three pin groups.
// Assumes pin levels arrive synchronous to clk_i; pad logic combines out/oe/pull-up.

module gpio_pullup_latch_logic (
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    input  wire gpio_pkg::cpu_req_s req_i,
    input  wire gpio_pkg::pins_t   pin_i,
    output logic [7:0]             rdata_o,
    output gpio_pkg::pins_t        pin_out_o,
    output gpio_pkg::pins_t        pin_oe_o,
    output gpio_pkg::pins_t        pull_up_o
);
    import gpio_pkg::*;

    function automatic reg_kind_e decode_kind(input logic [15:0] a);
        if (a == PORT_GRP2_ADDR || a == PORT_GRP3_ADDR || a == PORT_GRP4_ADDR) begin
            return KIND_PORT;
        end else if (a == DIR_GRP2_ADDR || a == DIR_GRP3_ADDR || a == DIR_GRP4_ADDR) begin
            return KIND_DIR;
        end else if (a == PU_GRP2_ADDR || a == PU_GRP3_ADDR || a == PU_GRP4_ADDR) begin
            return KIND_PU;
        end else begin
            return KIND_NONE;
        end
    endfunction

    function automatic logic [1:0] decode_grp(input logic [15:0] a);
        if (a[1:0] == 2'h2) begin
            return 2'h0;
        end else if (a[1:0] == 2'h3) begin
            return 2'h1;
        end else begin
            return 2'h2;
        end
    endfunction

    pins_t      dir_q;
    pins_t      dir_d;
    pins_t      latch_d;
    pins_t      pu_d;
    pins_t      port_rd;
    reg_kind_e  kind;
    logic [1:0] grp;
    logic [7:0] sel_rd;
    logic [7:0] bit_mask;
    logic [7:0] modified;
    logic [7:0] wval;
    logic       we;
    logic [7:0] cur_latch;
    logic [7:0] cur_dir;
    logic [7:0] cur_pin;

    assign kind      = decode_kind(req_i.addr);
    assign grp       = decode_grp(req_i.addr);
    assign we        = req_i.wr | req_i.bit_op;
    assign cur_latch = pin_out_o[grp];
    assign cur_dir   = dir_q[grp];
    assign cur_pin   = pin_i[grp];

    // Input bits show the pin, output bits the latch; input-only pins always the pin
    for (genvar g = 0; g < NGROUPS; g++) begin : g_rd
        assign port_rd[g] = (((pin_out_o[g] & ~dir_q[g]) | (pin_i[g] & dir_q[g]))
                             & LATCH_MASK[g]) | (pin_i[g] & IN_ONLY_MASK[g]);
    end

    assign sel_rd = (kind == KIND_PORT) ? port_rd[grp] :
                    (kind == KIND_DIR)  ? dir_q[grp]   :
                    (kind == KIND_PU)   ? pull_up_o[grp] : 8'h00;

    // A bit operation reads the whole byte, patches one bit and writes all eight back
    assign bit_mask = 8'h01 << req_i.bit_sel;
    assign modified = (sel_rd & ~bit_mask) | ({7'h00, req_i.bit_val} << req_i.bit_sel);
    assign wval     = req_i.bit_op ? modified : req_i.wdata;

    for (genvar g = 0; g < NGROUPS; g++) begin : g_reg
        logic hit;
        assign hit        = we && (grp == 2'(g));
        assign latch_d[g] = (hit && kind == KIND_PORT) ? (wval & LATCH_MASK[g])
                                                       : pin_out_o[g];
        assign dir_d[g]   = (hit && kind == KIND_DIR) ? (wval | ~DIR_MASK[g]) : dir_q[g];
        assign pu_d[g]    = (hit && kind == KIND_PU) ? (wval & PU_MASK[g])
                                                     : pull_up_o[g];

        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                pin_out_o[g] <= LATCH_RST;
                dir_q[g]     <= DIR_RST;
                pin_oe_o[g]  <= 8'h00;
                pull_up_o[g] <= PU_RST;
            end else begin
                pin_out_o[g] <= latch_d[g];
                dir_q[g]     <= dir_d[g];
                pin_oe_o[g]  <= ~dir_d[g] & DIR_MASK[g];
                pull_up_o[g] <= pu_d[g];
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= RDATA_RST;
        end else if (req_i.rd) begin
            rdata_o <= sel_rd;
        end
    end

    // Checking helpers
    logic [1:0] h_grp_q;
    logic [2:0] h_sel_q;
    logic [7:0] cur_pu;
    assign cur_pu = pull_up_o[grp];
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            h_grp_q <= 2'h0;
            h_sel_q <= 3'h0;
        end else begin
            h_grp_q <= grp;
            h_sel_q <= req_i.bit_sel;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    a_pu_unimpl_zero: assert property ((pull_up_o & ~PU_MASK) == '0)
        else $error("unimplemented pull-up bit set");

    a_pu_byte_write: assert property ((req_i.wr && !req_i.bit_op && kind == KIND_PU) |=>
        pull_up_o[h_grp_q] == ($past(req_i.wdata) & PU_MASK[h_grp_q]))
        else $error("pull-up byte write not stored");

    a_pu_bit_write: assert property ((req_i.bit_op && kind == KIND_PU) |=>
        pull_up_o[h_grp_q][h_sel_q] == ($past(req_i.bit_val) & PU_MASK[h_grp_q][h_sel_q]))
        else $error("pull-up bit write not stored");

    a_oe_from_dir: assert property (pin_oe_o == (~dir_q & DIR_MASK))
        else $error("driver enable disagrees with direction");

    a_latch_write: assert property ((req_i.wr && !req_i.bit_op && kind == KIND_PORT) |=>
        pin_out_o[h_grp_q] == ($past(req_i.wdata) & LATCH_MASK[h_grp_q]))
        else $error("port write not latched");

    a_latch_hold_read: assert property ((!we || kind != KIND_PORT) |=> $stable(pin_out_o))
        else $error("latch changed without a port write");

    a_read_out_mode: assert property ((req_i.rd && kind == KIND_PORT) |=>
        (rdata_o & ~$past(cur_dir) & LATCH_MASK[h_grp_q]) == ($past(cur_latch) & ~$past(cur_dir)))
        else $error("output-mode read not latch value");

    a_read_in_mode: assert property ((req_i.rd && kind == KIND_PORT) |=>
        (rdata_o & $past(cur_dir) & LATCH_MASK[h_grp_q])
            == ($past(cur_pin) & $past(cur_dir) & LATCH_MASK[h_grp_q]))
        else $error("input-mode read not pin level");

    a_rmw_in_mode: assert property ((req_i.bit_op && kind == KIND_PORT) |=>
        (pin_out_o[h_grp_q] & $past(cur_dir) & ~(8'h01 << h_sel_q))
            == ($past(cur_pin) & $past(cur_dir) & LATCH_MASK[h_grp_q] & ~(8'h01 << h_sel_q)))
        else $error("input-mode bit operation did not use pin level");

    a_rmw_out_mode: assert property ((req_i.bit_op && kind == KIND_PORT) |=>
        (pin_out_o[h_grp_q] & ~$past(cur_dir) & ~(8'h01 << h_sel_q))
            == ($past(cur_latch) & ~$past(cur_dir) & ~(8'h01 << h_sel_q)))
        else $error("output-mode bit operation did not use latch");

    // Registers change only when addressed, and unimplemented bits keep their fixed level
    a_dir_byte_write: assert property ((req_i.wr && !req_i.bit_op && kind == KIND_DIR) |=>
        dir_q[h_grp_q] == ($past(req_i.wdata) | ~DIR_MASK[h_grp_q]))
        else $error("direction byte write not stored");

    a_dir_hold: assert property ((!we || kind != KIND_DIR) |=> $stable(dir_q))
        else $error("direction changed without a direction write");

    a_dir_unimpl_one: assert property ((dir_q | DIR_MASK) == '1)
        else $error("unimplemented direction bit cleared");

    a_latch_unimpl_zero: assert property ((pin_out_o & ~LATCH_MASK) == '0)
        else $error("unimplemented latch bit set");

    a_latch_bit_write: assert property ((req_i.bit_op && kind == KIND_PORT) |=>
        pin_out_o[h_grp_q][h_sel_q] == ($past(req_i.bit_val) & LATCH_MASK[h_grp_q][h_sel_q]))
        else $error("port bit operation did not store the bit");

    a_pu_hold: assert property ((!we || kind != KIND_PU) |=> $stable(pull_up_o))
        else $error("pull-up select changed without a write");

    a_pu_bit_keep: assert property ((req_i.bit_op && kind == KIND_PU) |=>
        (pull_up_o[h_grp_q] & ~(8'h01 << h_sel_q))
            == ($past(cur_pu) & ~(8'h01 << h_sel_q)))
        else $error("pull-up bit write disturbed other bits");

    a_rdata_hold: assert property (!req_i.rd |=> $stable(rdata_o))
        else $error("read data changed without a read");

    a_unmapped_read: assert property ((req_i.rd && kind == KIND_NONE) |=>
        rdata_o == 8'h00)
        else $error("unmapped read not zero");

    c_pu_write: cover property (req_i.wr && kind == KIND_PU && req_i.wdata != 8'h00);
    c_bit_op_mixed: cover property (req_i.bit_op && kind == KIND_PORT
                                    && cur_dir != 8'hff && cur_dir != ~DIR_MASK[grp]);
    c_port_read: cover property (req_i.rd && kind == KIND_PORT ##1 req_i.wr);
    c_dir_bit_op: cover property (req_i.bit_op && kind == KIND_DIR);
    c_in_only_read: cover property (req_i.rd && kind == KIND_PORT && grp == 2'h1 && cur_pin[4]);

endmodule

// [rtl/gpio_pkg.sv]
// Constants, masks and carrier types for the general-purpose port block.
// Assumes the processor presents one byte access or one bit operation per cycle.
package gpio_pkg;

    localparam int NGROUPS = 3;

    localparam logic [15:0] PORT_GRP2_ADDR = 16'hff02;
    localparam logic [15:0] PORT_GRP3_ADDR = 16'hff03;
    localparam logic [15:0] PORT_GRP4_ADDR = 16'hff04;
    localparam logic [15:0] DIR_GRP2_ADDR  = 16'hff22;
    localparam logic [15:0] DIR_GRP3_ADDR  = 16'hff23;
    localparam logic [15:0] DIR_GRP4_ADDR  = 16'hff24;
    localparam logic [15:0] PU_GRP2_ADDR   = 16'hff32;
    localparam logic [15:0] PU_GRP3_ADDR   = 16'hff33;
    localparam logic [15:0] PU_GRP4_ADDR   = 16'hff34;

    // Index 0 is group two, 1 group three, 2 group four
    localparam logic [2:0][7:0] LATCH_MASK   = {8'h09, 8'h04, 8'h0f};
    localparam logic [2:0][7:0] DIR_MASK     = {8'h09, 8'h04, 8'h0f};
    localparam logic [2:0][7:0] PU_MASK      = {8'h09, 8'h14, 8'h0f};
    localparam logic [2:0][7:0] IN_ONLY_MASK = {8'h00, 8'h10, 8'h00};

    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DIR_RST   = 8'hff;
    localparam logic [7:0] PU_RST    = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;

    typedef enum logic [1:0] {KIND_NONE, KIND_PORT, KIND_DIR, KIND_PU} reg_kind_e;

    typedef logic [2:0][7:0] pins_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic        bit_op;
        logic [2:0]  bit_sel;
        logic        bit_val;
        logic [7:0]  wdata;
    } cpu_req_s;

endpackage

// [verification/pin_partner.sv]
// External devices on the port pins: each pin has its own source level.
// Assumes the port wins wherever its driver enable is high; a pin released by both
// sides rests at its pull-up level, or low where no pull-up is connected.
module pin_partner
    import gpio_pkg::*;
(
    input  wire gpio_pkg::pins_t pin_out_i,
    input  wire gpio_pkg::pins_t pin_oe_i,
    input  wire gpio_pkg::pins_t pull_up_i,
    input  wire gpio_pkg::pins_t ext_en_i,
    input  wire gpio_pkg::pins_t ext_i,
    output gpio_pkg::pins_t      pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    assign pin_o = (pin_out_i & pin_oe_i)
                 | (~pin_oe_i & ((ext_i & ext_en_i) | (pull_up_i & ~ext_en_i)));
endmodule

// [verification/gpio_pullup_latch_logic_tb.sv]
// Self-checking bench for the port block, with the external pin model.
// Assumes one register request per cycle, driven 5 ns after the edge.
module gpio_pullup_latch_logic_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import gpio_pkg::*;
    logic       clk_i = 1'b0;
    logic       arst_n_i = 1'b0;
    cpu_req_s   req_i = '0;
    pins_t      ext = '0;
    pins_t      ext_en = '1;
    pins_t      pin_i, pin_out_o, pin_oe_o, pull_up_o;
    logic [7:0] rdata_o;
    int         n_fail = 0;
    int         tests_run = 0;

    always #25 clk_i = ~clk_i;

    gpio_pullup_latch_logic DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req_i),
        .pin_i(pin_i), .rdata_o(rdata_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
        .pull_up_o(pull_up_o));
    pin_partner ext_dev (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .pull_up_i(pull_up_o),
        .ext_en_i(ext_en), .ext_i(ext), .pin_o(pin_i));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Op 1 byte write, 2 read, 3 bit op with index d[2:0] and value d[3]
    task automatic acc(input logic [15:0] a, input logic [1:0] op, input logic [7:0] d);
        req_i = {a, op == 2'd1, op == 2'd2, op == 2'd3, d[2:0], d[3], d};
        @(posedge clk_i);
        #5 req_i = '0;
        // Idle edge so that a following call never reassigns req_i in the same time step
        @(posedge clk_i);
        #5;
    endtask

    task automatic t_reset;
        for (int g = 0; g < NGROUPS; g++) begin
            chk(pull_up_o[g], 8'h00);
            chk(pin_out_o[g], 8'h00);
            chk(pin_oe_o[g], 8'h00);
        end
        acc(DIR_GRP2_ADDR, 2'd2, 8'h00);
        chk(rdata_o, 8'hff);
    endtask

    task automatic t_pullup;
        logic [15:0] a [3] = '{PU_GRP2_ADDR, PU_GRP3_ADDR, PU_GRP4_ADDR};
        for (int g = 0; g < NGROUPS; g++) begin
            acc(a[g], 2'd1, 8'hff);
            chk(pull_up_o[g], PU_MASK[g]);
            acc(a[g], 2'd2, 8'h00);
            chk(rdata_o, PU_MASK[g]);
        end
        acc(16'hff35, 2'd2, 8'h00);
        chk(rdata_o, 8'h00);
        acc(PU_GRP3_ADDR, 2'd1, 8'h00);
        chk(pull_up_o[1], 8'h00);
        acc(PU_GRP3_ADDR, 2'd3, 8'h0c);
        chk(pull_up_o[1], 8'h10);
        acc(PU_GRP3_ADDR, 2'd3, 8'h0f);
        chk(pull_up_o[1], 8'h10);
    endtask

    task automatic t_output;
        ext[0] = 8'hff;
        acc(DIR_GRP2_ADDR, 2'd1, 8'h00);
        chk(pin_oe_o[0], 8'h0f);
        acc(PORT_GRP2_ADDR, 2'd1, 8'h05);
        chk(pin_out_o[0], 8'h05);
        chk(pin_i[0], 8'hf5);
        acc(PORT_GRP2_ADDR, 2'd2, 8'h00);
        chk(rdata_o, 8'h05);
        acc(PORT_GRP2_ADDR, 2'd3, 8'h09);
        repeat (3) @(posedge clk_i);
        #5 chk(pin_out_o[0], 8'h07);
        chk(pin_i[0], 8'hf7);
    endtask

    task automatic t_input;
        ext[2] = 8'h08;
        acc(PORT_GRP4_ADDR, 2'd1, 8'h09);
        chk(pin_out_o[2], 8'h09);
        chk(pin_oe_o[2], 8'h00);
        chk(pin_i[2], 8'h08);
        acc(PORT_GRP4_ADDR, 2'd2, 8'h00);
        chk(rdata_o, 8'h08);
        chk(pin_out_o[2], 8'h09);
        // Clearing bit 3 works on the pin level, so bit 0 follows the low pin
        acc(PORT_GRP4_ADDR, 2'd3, 8'h03);
        chk(pin_out_o[2], 8'h00);
        chk(pin_oe_o[2], 8'h00);
    endtask

    // Group three: input-only bit 4, bit 2 turned to output by a bit operation
    task automatic t_mixed;
        ext[1] = 8'h10;
        acc(PORT_GRP3_ADDR, 2'd2, 8'h00);
        chk(rdata_o, 8'h10);
        acc(DIR_GRP3_ADDR, 2'd3, 8'h02);
        chk(pin_oe_o[1], 8'h04);
        acc(PORT_GRP3_ADDR, 2'd3, 8'h0a);
        chk(pin_out_o[1], 8'h04);
        chk(pin_i[1], 8'h14);
        ext_en[1] = 8'h00;
        acc(PORT_GRP3_ADDR, 2'd2, 8'h00);
        chk(rdata_o, 8'h14);
        acc(PU_GRP3_ADDR, 2'd1, 8'h00);
        acc(PORT_GRP3_ADDR, 2'd2, 8'h00);
        chk(rdata_o, 8'h04);
    endtask

    task automatic t_rereset;
        arst_n_i = 1'b0;
        #10 chk(pin_out_o[0], 8'h00);
        chk(pin_oe_o[0], 8'h00);
        chk(pull_up_o[1], 8'h00);
        @(posedge clk_i);
        #5 arst_n_i = 1'b1;
        chk(pin_out_o[1], 8'h00);
        acc(DIR_GRP3_ADDR, 2'd2, 8'h00);
        chk(rdata_o, 8'hff);
    endtask

    task automatic end_sim;
        if (n_fail == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        #5 arst_n_i = 1'b1;
        t_reset();
        t_pullup();
        t_output();
        t_input();
        t_mixed();
        t_rereset();
        end_sim();
    end

    initial begin
        #20000;
        n_fail++;
        end_sim();
    end
endmodule
